/* common/ser_pkg.sv */
package ser_pkg;
   // Event register bit positions
   localparam int EV_OPC = 0;
   localparam int EV_QYE = 2;
   localparam int EV_DDE = 3;
   localparam int EV_EXE = 4;
   localparam int EV_CME = 5;
   localparam int EV_PON = 7;
   localparam int EV_WIDTH = 16;
   localparam int MASK_WIDTH = 8;

   // Status byte bit positions
   localparam int SB_MAV = 4;
   localparam int SB_ESB = 5;
   localparam int SB_RQS = 6;

   // Reset values and masks
   localparam logic [15:0] EVENT_FLAGS_RESET = 16'h0080;
   localparam logic [15:0] EVENT_USED_BITS   = 16'h00BD;
   localparam logic [7:0]  SRQ_MASK_RESET    = 8'h00;
   localparam logic [7:0]  EVENT_MASK_RESET  = 8'h00;
   localparam logic [7:0]  MSS_SOURCE_BITS   = 8'hBF;

   // Output queue shape: data byte plus end-of-message marker
   localparam int OQ_DATA_WIDTH = 8;
   localparam int OQ_WIDTH      = 9;
   localparam int OQ_DEPTH      = 16;
endpackage : ser_pkg

/* common/ser_oq_if.sv */
`timescale 1ns/100ps
interface ser_oq_if #(parameter int WIDTH = 9);
   logic             push;
   logic [WIDTH-1:0] push_data;
   logic             pop;
   logic [WIDTH-1:0] head;
   logic             clear;
   logic             empty;
   logic             full;
   logic             next_full;
   logic             next_empty;

   modport owner (output push, push_data, pop, clear,
                  input  head, empty, full, next_full, next_empty);
   modport queue (input  push, push_data, pop, clear,
                  output head, empty, full, next_full, next_empty);
endinterface : ser_oq_if

/* src/ser_output_queue.sv */
`timescale 1ns/100ps
module ser_output_queue
   import ser_pkg::*;
#(
   parameter int DEPTH = OQ_DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Queue side
   ser_oq_if.queue  q
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0]   DEPTH_C = (AW + 1)'(DEPTH);
   localparam logic [AW-1:0] LAST_C  = AW'(DEPTH - 1);

   logic [OQ_WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]       wr_ptr;
   logic [AW-1:0]       rd_ptr;
   logic [AW:0]         count;
   logic [AW:0]         next_count;
   logic                do_push;
   logic                do_pop;

   function automatic logic [AW-1:0] ptr_step(input logic [AW-1:0] p);
      return (p == LAST_C) ? '0 : p + 1'b1;
   endfunction : ptr_step

   // A pop frees room in the same cycle, so a full queue still takes a push
   assign do_pop  = q.pop && (count != '0);
   assign do_push = q.push && ((count != DEPTH_C) || do_pop);

   always_comb begin
      next_count = count;
      if (q.clear) begin
         next_count = '0;
      end else if (do_push && !do_pop) begin
         next_count = count + 1'b1;
      end else if (do_pop && !do_push) begin
         next_count = count - 1'b1;
      end
   end

   assign q.head       = mem[rd_ptr];
   assign q.empty      = (count == '0);
   assign q.full       = (count == DEPTH_C);
   assign q.next_full  = (next_count == DEPTH_C);
   assign q.next_empty = (next_count == '0);

   always_ff @(posedge clk) begin
      if (reset || q.clear) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         count <= next_count;
         if (do_push) begin
            wr_ptr <= ptr_step(wr_ptr);
         end
         if (do_pop) begin
            rd_ptr <= ptr_step(rd_ptr);
         end
      end
   end

   // Storage needs no reset; contents are only read behind count
   always_ff @(posedge clk) begin
      if (do_push && !q.clear) begin
         mem[wr_ptr] <= q.push_data;
      end
   end
endmodule : ser_output_queue

/* src/ser_status_top.sv */
// Overview of operation
// [R01] Eight-bit service request mask, controller writable
// [R02] Operation-complete bit set when armed, nothing pending
// [R03] Query error on read of empty, idle queue
// [R04] Query error when queued response data lost
// [R05] Device-dependent error sets bit three
// [R06] Execution error sets bit four
// [R07] Command syntax error sets bit five
// [R08] Supply off-to-on transition sets bit seven
// [R09] Eight-bit event mask maps onto low bits
// [R10] Event summary is OR of enabled events
// [R11] Message-available bit high while unread messages
// [R12] Formatter places data bytes and end markers
// [R13] Reads remove messages; empty clears message-available
// [R14] Controller waits on message-available before reading
// [R15] Service request sets bit six and line
// [R16] Bit six identical for poll and query
// [R17] Unused event bits read zero always
// [R18] Summary from masked bits; request on rise
`timescale 1ns/100ps
module ser_status_top
   import ser_pkg::*;
#(
   parameter int DEPTH = OQ_DEPTH
) (
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     reset,
   // Event sources, one-cycle pulses except the level ops_pending
   input  wire logic                     opc_request,
   input  wire logic                     ops_pending,
   input  wire logic                     device_error,
   input  wire logic                     execution_error,
   input  wire logic                     command_error,
   // Supply good pin, asynchronous
   input  wire logic                     power_good,
   // Mask writes and event register read
   input  wire logic                     srq_mask_write,
   input  wire logic [MASK_WIDTH-1:0]    srq_mask_wdata,
   input  wire logic                     event_mask_write,
   input  wire logic [MASK_WIDTH-1:0]    event_mask_wdata,
   input  wire logic                     event_read,
   output logic      [MASK_WIDTH-1:0]    service_request_mask,
   output logic      [MASK_WIDTH-1:0]    standard_event_mask,
   output logic      [EV_WIDTH-1:0]      event_rdata,
   // Response formatter
   input  wire logic                     resp_valid,
   input  wire logic [OQ_DATA_WIDTH-1:0] resp_data,
   input  wire logic                     resp_end,
   input  wire logic                     resp_pending,
   output logic                          resp_ready,
   // Controller side
   input  wire logic                     ctl_read,
   input  wire logic                     queue_clear,
   input  wire logic                     serial_poll,
   output logic      [OQ_DATA_WIDTH-1:0] ctl_rdata,
   output logic                          ctl_rend,
   output logic                          ctl_rvalid,
   output logic      [7:0]               status_byte,
   output logic                          srq_line
);
   ser_oq_if #(.WIDTH(OQ_WIDTH)) oq ();

   ser_output_queue #(.DEPTH(DEPTH)) u_queue (
      .clk   (clk),
      .reset (reset),
      .q     (oq)
   );

   logic [EV_WIDTH-1:0] standard_event_flags;
   logic [EV_WIDTH-1:0] next_flags;
   logic [EV_WIDTH-1:0] event_sets;
   logic                opc_armed;
   logic                pg_meta;
   logic                pg_s2;
   logic                pg_s3;
   logic                pg_stable;
   logic                power_rise;
   logic                read_empty;
   logic                data_lost;
   logic                event_summary_bit;
   logic                message_available_bit;
   logic                master_summary_bit;
   logic                mss_q;
   logic [7:0]          next_status;

   // Supply pin: three stages, change counted once stages two and three agree
   always_ff @(posedge clk) begin
      if (reset) begin
         pg_meta <= 1'b0;
         pg_s2   <= 1'b0;
         pg_s3   <= 1'b0;
      end else begin
         pg_meta <= power_good;
         pg_s2   <= pg_meta;
         pg_s3   <= pg_s2;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         pg_stable <= 1'b0;
      end else if (pg_s2 == pg_s3) begin
         pg_stable <= pg_s3;
      end
   end

   assign power_rise = (pg_s2 == pg_s3) && pg_s3 && !pg_stable; // [R08]

   // Completion monitoring arms on request and fires once work drains
   always_ff @(posedge clk) begin
      if (reset) begin
         opc_armed <= 1'b0;
      end else if (opc_request) begin
         opc_armed <= 1'b1;
      end else if (opc_armed && !ops_pending) begin
         opc_armed <= 1'b0;
      end
   end

   // Reads with nothing queued or coming are query errors, not stalls
   assign read_empty = ctl_read && oq.empty && !resp_pending; // [R03]
   // Pushing without room, or flushing unread data, drops responses
   assign data_lost  = (resp_valid && !resp_ready)
                     || (queue_clear && !oq.empty); // [R04]

   always_comb begin
      event_sets         = '0;
      event_sets[EV_OPC] = opc_armed && !opc_request && !ops_pending; // [R02]
      event_sets[EV_QYE] = read_empty || data_lost;
      event_sets[EV_DDE] = device_error; // [R05]
      event_sets[EV_EXE] = execution_error; // [R06]
      event_sets[EV_CME] = command_error; // [R07]
      event_sets[EV_PON] = power_rise;
   end

   // Read clears the flags; a set in the same cycle survives
   always_comb begin
      next_flags = standard_event_flags;
      if (event_read) begin
         next_flags = '0;
      end
      next_flags = (next_flags | event_sets) & EVENT_USED_BITS; // [R17]
   end

   // Reset counts as a power-on, so the flag starts set
   always_ff @(posedge clk) begin
      if (reset) begin
         standard_event_flags <= EVENT_FLAGS_RESET; // [R08]
      end else begin
         standard_event_flags <= next_flags;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         event_rdata <= '0;
      end else if (event_read) begin
         event_rdata <= standard_event_flags & EVENT_USED_BITS; // [R17]
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         service_request_mask <= SRQ_MASK_RESET;
      end else if (srq_mask_write) begin
         service_request_mask <= srq_mask_wdata; // [R01]
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         standard_event_mask <= EVENT_MASK_RESET;
      end else if (event_mask_write) begin
         standard_event_mask <= event_mask_wdata; // [R09]
      end
   end

   // Response formatter into the queue
   assign oq.push      = resp_valid && resp_ready;
   assign oq.push_data = {resp_end, resp_data}; // [R12]
   assign oq.pop       = ctl_read && !oq.empty; // [R13]
   assign oq.clear     = queue_clear;

   // Ready follows next-cycle room, so an accepted push never overflows
   always_ff @(posedge clk) begin
      if (reset) begin
         resp_ready <= 1'b0;
      end else begin
         resp_ready <= !oq.next_full;
      end
   end

   // A read while a response is pending but not queued returns nothing
   always_ff @(posedge clk) begin
      if (reset) begin
         ctl_rvalid <= 1'b0;
         ctl_rdata  <= '0;
         ctl_rend   <= 1'b0;
      end else begin
         ctl_rvalid <= oq.pop; // [R14]
         if (oq.pop) begin
            ctl_rdata <= oq.head[OQ_DATA_WIDTH-1:0];
            ctl_rend  <= oq.head[OQ_WIDTH-1];
         end
      end
   end

   // Status byte built from the current masks and the flag and queue values stored at the end of this cycle
   always_comb begin
      event_summary_bit     = |(next_flags[MASK_WIDTH-1:0] & standard_event_mask); // [R10]
      message_available_bit = !oq.next_empty; // [R11]
      next_status           = '0;
      next_status[SB_ESB]   = event_summary_bit;
      next_status[SB_MAV]   = message_available_bit; // [R13]
      master_summary_bit    = |(next_status & service_request_mask & MSS_SOURCE_BITS); // [R18]
      next_status[SB_RQS]   = master_summary_bit; // [R16]
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         status_byte <= '0;
         mss_q       <= 1'b0;
      end else begin
         status_byte <= next_status; // [R15]
         mss_q       <= master_summary_bit;
      end
   end

   // Line rises on a new summary; a poll drops it, a new rise wins
   always_ff @(posedge clk) begin
      if (reset) begin
         srq_line <= 1'b0;
      end else if (master_summary_bit && !mss_q) begin
         srq_line <= 1'b1; // [R15]
      end else if (serial_poll || !master_summary_bit) begin
         srq_line <= 1'b0;
      end
   end
endmodule : ser_status_top

/* tb/ser_status_chk.sv */
`timescale 1ns/100ps
module ser_status_chk
   import ser_pkg::*;
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        reset,
   // Watched ports
   input wire logic        srq_mask_write,
   input wire logic [7:0]  srq_mask_wdata,
   input wire logic        event_mask_write,
   input wire logic [7:0]  event_mask_wdata,
   input wire logic        ctl_read,
   input wire logic        ctl_rvalid,
   input wire logic        resp_ready,
   input wire logic        srq_line,
   input wire logic [7:0]  service_request_mask,
   input wire logic [7:0]  standard_event_mask,
   input wire logic [7:0]  status_byte,
   input wire logic [15:0] event_rdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   property p_srqm; srq_mask_write |=> service_request_mask == $past(srq_mask_wdata); endproperty
   a_srqm: assert property (p_srqm) else $error("srq mask write lost");
   property p_evm; event_mask_write |=> standard_event_mask == $past(event_mask_wdata); endproperty
   a_evm: assert property (p_evm) else $error("event mask write lost");
   property p_unused; event_rdata[15:8] == 8'h00 && !event_rdata[6] && !event_rdata[1]; endproperty
   a_unused: assert property (p_unused) else $error("unused event bit set");
   property p_mss; status_byte[6] == |(status_byte & service_request_mask & MSS_SOURCE_BITS); endproperty
   a_mss: assert property (p_mss) else $error("master summary wrong");
   property p_rise; $rose(status_byte[6]) |-> srq_line; endproperty
   a_rise: assert property (p_rise) else $error("no service request");
   property p_srq; srq_line |-> status_byte[6]; endproperty
   a_srq: assert property (p_srq) else $error("request without summary");
   property p_rv; ctl_rvalid |-> $past(ctl_read); endproperty
   a_rv: assert property (p_rv) else $error("read data without read");
   property p_full; $fell(resp_ready) |-> status_byte[4]; endproperty
   a_full: assert property (p_full) else $error("full queue not available");
   property p_esb; status_byte[5] |-> standard_event_mask != 8'h00; endproperty
   a_esb: assert property (p_esb) else $error("summary with empty mask");
   c_srq: cover property ($rose(srq_line));
   c_rv: cover property (ctl_rvalid);
   c_full: cover property ($fell(resp_ready));
endmodule : ser_status_chk

bind ser_status_top ser_status_chk chk_u (.clk, .reset, .srq_mask_write, .srq_mask_wdata,
   .event_mask_write, .event_mask_wdata, .ctl_read, .ctl_rvalid, .resp_ready, .srq_line,
   .service_request_mask, .standard_event_mask, .status_byte, .event_rdata);

/* tb/ser_ctl_model.sv */
`timescale 1ns/100ps
module ser_ctl_model (
   // Clock
   input wire logic       clk,
   // Pacing and status
   input wire logic       enable,
   input wire logic       slow,
   input wire logic [7:0] status_byte,
   // Read strobe
   output logic           ctl_read
);
   initial ctl_read = 1'b0;
   // Looks after the edge so a read just taken has already updated bit 4
   always @(posedge clk) begin
      #1;
      ctl_read = enable && status_byte[4] && !(slow && $urandom_range(1));
   end
endmodule : ser_ctl_model

/* tb/status_event_reporting_tb.sv */
`timescale 1ns/100ps
module status_event_reporting_tb
   import ser_pkg::*;
   ;
   localparam int D = 4;
   logic clk = 0, reset = 1, opc_request = 0, ops_pending = 0, device_error = 0;
   logic execution_error = 0, command_error = 0, power_good = 0, srq_mask_write = 0;
   logic event_mask_write = 0, event_read = 0, resp_valid = 0, resp_end = 0, serial_poll = 0;
   logic ctl_en = 0, slow = 0, bad_rd = 0, ctl_read, resp_ready, ctl_rend, ctl_rvalid, srq_line;
   logic [7:0] srq_mask_wdata = 0, event_mask_wdata = 0, resp_data = 0, ctl_rdata, status_byte;
   logic [7:0] service_request_mask, standard_event_mask, m;
   logic [15:0] event_rdata, flags = 16'h0080;
   logic [2:0] e;
   logic [8:0] q[$];
   int errors = 0, n_tests = 0, cyc = 0;

   ser_status_top #(.DEPTH(D)) dut_u (.clk, .reset, .opc_request, .ops_pending, .device_error,
      .execution_error, .command_error, .power_good, .srq_mask_write, .srq_mask_wdata,
      .event_mask_write, .event_mask_wdata, .event_read, .service_request_mask,
      .standard_event_mask, .event_rdata, .resp_valid, .resp_data, .resp_end,
      .resp_pending(1'b0), .resp_ready, .ctl_read(ctl_read | bad_rd), .queue_clear(1'b0),
      .serial_poll, .ctl_rdata, .ctl_rend, .ctl_rvalid, .status_byte, .srq_line);
   ser_ctl_model ctl_u (.clk, .enable(ctl_en), .slow, .status_byte, .ctl_read);

   always #2.5 clk = ~clk;

   task automatic finish_test();
      $display("checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : finish_test

   task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic tick(int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic rd_ev();
      event_read = 1;
      tick();
      event_read = 0;
      tick();
      check("event", event_rdata, flags);
      flags = 0;
   endtask : rd_ev

   // Never offers a byte while full, so no data is lost here
   task automatic push_n(int n);
      for (int i = 0; i < n; i++) begin
         while (resp_ready !== 1'b1) begin
            resp_valid = 0;
            tick();
         end
         resp_valid = 1;
         resp_data = $urandom;
         resp_end = (i % 3 == 2);
         q.push_back({resp_end, resp_data});
         tick();
      end
      resp_valid = 0;
   endtask : push_n

   task automatic drain();
      ctl_en = 1;
      while (status_byte[4] !== 1'b0) tick();
      tick(2);
      check("left", q.size(), 0);
   endtask : drain

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         finish_test();
      end
      if (ctl_rvalid === 1'b1 && !reset)
         check("rdata", {ctl_rend, ctl_rdata}, q.pop_front());
   end

   initial begin
      void'($urandom(32'h0AEDB769));
      tick(12);
      reset = 0;
      tick();
      rd_ev();
      power_good = 1;
      tick(8);
      flags = 16'h0080;
      rd_ev();
      for (int i = 0; i < 8; i++) begin
         m = $urandom;
         e = $urandom_range(7, 1);
         event_mask_wdata = m;
         event_mask_write = 1;
         {command_error, execution_error, device_error} = e;
         tick();
         {event_mask_write, command_error, execution_error, device_error} = 0;
         flags = {8'h00, 2'b00, e, 3'b000};
         tick(2);
         check("esb", status_byte[5], |(flags[7:0] & m));
         rd_ev();
      end
      {srq_mask_write, event_mask_write} = 2'b11;
      {srq_mask_wdata, event_mask_wdata} = 16'h2020;
      tick();
      {srq_mask_write, event_mask_write, command_error} = 3'b001;
      tick();
      command_error = 0;
      flags = 16'h0020;
      tick(2);
      check("srq", {status_byte[6], srq_line}, 2'b11);
      serial_poll = 1;
      tick();
      serial_poll = 0;
      tick(2);
      check("poll", {status_byte[6], srq_line}, 2'b10);
      rd_ev();
      ops_pending = 1;
      opc_request = 1;
      tick();
      opc_request = 0;
      tick(4);
      rd_ev();
      ops_pending = 0;
      tick(4);
      flags = 16'h0001;
      rd_ev();
      slow = 1;
      ctl_en = 1;
      push_n(20);
      drain();
      ctl_en = 0;
      push_n(D);
      tick();
      check("full", {resp_ready, status_byte[4]}, 2'b01);
      resp_valid = 1;
      tick();
      resp_valid = 0;
      drain();
      flags = 16'h0004;
      rd_ev();
      bad_rd = 1;
      tick();
      bad_rd = 0;
      tick(2);
      flags = 16'h0004;
      rd_ev();
      finish_test();
   end
endmodule : status_event_reporting_tb
